// File: src/rop_pkg.sv
// package for the receive output port: widths, policy codes, modes, states
// assumes every user sits on the single 100 MHz core clock
`default_nettype none
package rop_pkg;
   localparam int ROP_RAW_W = 12;          // widest line character
   localparam int ROP_DEC_W = 10;          // widest decoded character
   localparam int ROP_MAP_W = 14;          // mapped output word width
   localparam int ROP_FIFO_DEPTH = 32;     // receive fifo depth
   // mapped word field positions
   localparam int ROP_F_CMD0 = 10;         // command bit 0
   localparam int ROP_F_CMD1 = 11;         // command bit 1
   localparam int ROP_F_SCD = 12;          // data or command flag
   localparam int ROP_F_VIOL = 13;         // code violation flag
   // discard policy codes
   localparam logic [1:0] ROP_POL_KEEP = 2'h0;  // keep everything
   localparam logic [1:0] ROP_POL_SYNC = 2'h1;  // collapse sync runs
   // decoded command codes, values arbitrary
   localparam logic [9:0] ROP_CMD_SYNC_PRI = 10'h011;   // sync_char_primary
   localparam logic [9:0] ROP_CMD_SYNC_ALT = 10'h012;   // sync_char_alternate
   localparam logic [9:0] ROP_CMD_NULL = 10'h000;       // null_fill_character
   // raw line sync patterns per width, values arbitrary
   localparam logic [11:0] ROP_SYNC10_PRI = 12'h0F8;
   localparam logic [11:0] ROP_SYNC10_ALT = 12'h307;
   localparam logic [11:0] ROP_SYNC12_PRI = 12'h3F8;
   localparam logic [11:0] ROP_SYNC12_ALT = 12'hC07;
   localparam logic [11:0] ROP_MASK10 = 12'h3FF;        // ten bit window mask
   localparam logic [11:0] ROP_MASK12 = 12'hFFF;        // twelve bit window mask
   localparam logic [3:0] ROP_OFF_RESET = 4'h0;         // alignment offset at reset
   // bus mapping modes
   typedef enum logic [1:0] {
      ROP_MODE_ENC8 = 2'b00,
      ROP_MODE_ENC10 = 2'b01,
      ROP_MODE_RAW10 = 2'b10,
      ROP_MODE_RAW12 = 2'b11
   } rop_mode_t;
   // host read phases
   typedef enum logic [1:0] {
      ROP_ST_IDLE = 2'b00,
      ROP_ST_ADDR = 2'b01,
      ROP_ST_DRIVE = 2'b10
   } rop_state_t;
endpackage
`default_nettype wire

// File: src/rop_fifo_if.sv
// handshake carrier between the port logic and its receive fifo
// assumes both ends share one clock
`timescale 1ns/1ns
`default_nettype none
interface rop_fifo_if #(parameter int W = 14);
   logic wr_valid;     // write request
   logic wr_ready;     // fifo has room
   logic [W-1:0] wr_data;   // write word
   logic rd_valid;     // fifo holds a word
   logic rd_ready;     // reader takes the word
   logic [W-1:0] rd_data;   // head word
   modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
   modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

// File: src/rop_fifo.sv
// receive fifo with valid and ready on both sides
// assumes a single clock and active low asynchronous reset
`timescale 1ns/1ns
`default_nettype none
module rop_fifo #(
   parameter int W = 14,     // word width
   parameter int DEPTH = 32  // entries
) (
   input wire logic clk_i,   // core clock
   input wire logic rstn_i,  // async reset, low active
   rop_fifo_if.fifo f        // both handshakes
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];      // storage
   logic [AW:0] wp_r;              // write pointer with wrap bit
   logic [AW:0] rp_r;              // read pointer with wrap bit
   logic push;                     // word written
   logic pop;                      // word removed

   // honest full and empty from the wrap bits
   assign f.wr_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
   assign f.rd_valid = (wp_r != rp_r);
   assign f.rd_data = mem[rp_r[AW-1:0]];
   assign push = f.wr_valid && f.wr_ready;
   assign pop = f.rd_ready && f.rd_valid;

   // storage write, no reset needed
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp_r[AW-1:0]] <= f.wr_data;
      end
   end

   // pointers
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: src/rop_port.sv
// receive output port: framing, discard policy, bus mapping, host read
// assumes decoder, deserialiser and host all run on clk_i
`timescale 1ns/1ns
`default_nettype none
//
// Behaviour
// - policy zero keeps every received character
// - policy one keeps only last sync of run
// - policy upper bit drops every null fill
// - bus floats while chip select sampled high
// - read enable after select drives bus, pops
// - mode pins choose output bit assignment
// - eight bit encoded nibble placement
// - ten bit encoded five bit placement
// - raw ten bits straight onto bus
// - raw twelve: bits ten, eleven on command
// - raw bit zero is earliest line bit
// - both bypassed: every character straight through
// - framed after sync seen: aligned characters
// - unframed or no sync: alignment not guaranteed
module rop_port
   import rop_pkg::*;
(
   input wire logic clk_i,                 // core clock
   input wire logic rstn_i,                // async reset, low active
   input wire logic [1:0] policy_i,        // discard policy select
   input wire logic encoder_bypass_n_i,    // low: decoder bypassed
   input wire logic char_width_select_i,   // high: 8 bit / raw 10
   input wire logic fifo_bypass_select_i,  // high: no fifo
   input wire logic framing_enable_i,      // allow realignment
   input wire logic raw_valid_i,           // line word valid
   input wire logic [11:0] raw_bits_i,     // line word, bit 0 earliest
   output logic raw_ready_o,               // line word taken
   output logic [11:0] framed_word_o,      // aligned word to decoder
   output logic sync_seen_o,               // alignment locked
   input wire logic dec_valid_i,           // decoded char valid
   input wire logic [9:0] dec_bits_i,      // decoded char
   input wire logic dec_cmd_i,             // decoded char is command
   input wire logic dec_viol_i,            // decoder code violation
   output logic dec_ready_o,               // decoded char taken
   input wire logic cs_n_i,                // chip select, low active
   input wire logic receive_read_enable_n_i, // read enable, low active
   output logic [9:0] receive_char_bus_o,  // data bus value
   output logic [1:0] receive_command_bits_o, // command bits 1..0
   output logic data_or_command_flag_o,    // high: command
   output logic code_violation_flag_o,     // violation seen
   output logic receive_bus_oe_n_o,        // low: bus driven
   output logic fifo_empty_o               // nothing to read
);
   rop_fifo_if #(.W(ROP_MAP_W)) ff ();     // fifo carrier

   rop_fifo #(.W(ROP_MAP_W), .DEPTH(ROP_FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .f(ff.fifo)
   );

   // decode the mode pins into a mapping mode
   function automatic rop_mode_t mode_of(input logic enc_n, input logic w8);
      rop_mode_t m;
      m = ROP_MODE_ENC8;
      case ({enc_n, w8})
         2'b11: m = ROP_MODE_ENC8;
         2'b10: m = ROP_MODE_ENC10;
         2'b01: m = ROP_MODE_RAW10;
         2'b00: m = ROP_MODE_RAW12;
         default: m = ROP_MODE_ENC8;
      endcase
      return m;
   endfunction

   // place a character on the output pins for the given mode
   function automatic logic [13:0] map_char(input rop_mode_t m, input logic [11:0] w,
                                            input logic cmd, input logic viol);
      logic [13:0] o;
      o = '0;
      case (m)
         ROP_MODE_ENC8: begin
            o[7:4] = w[7:4];
            if (cmd) begin
               o[8] = w[3];
               o[9] = w[2];
               o[ROP_F_CMD1] = w[1];
               o[ROP_F_CMD0] = w[0];
            end else begin
               o[3:0] = w[3:0];
            end
            o[ROP_F_SCD] = cmd;
            o[ROP_F_VIOL] = viol;
         end
         ROP_MODE_ENC10: begin
            o[8:4] = w[9:5];
            if (cmd) begin
               o[ROP_F_CMD1] = w[1];
               o[ROP_F_CMD0] = w[0];
            end else begin
               o[9] = w[4];
               o[3:0] = w[3:0];
            end
            o[ROP_F_SCD] = cmd;
            o[ROP_F_VIOL] = viol;
         end
         ROP_MODE_RAW10: begin
            o[9:0] = w[9:0];
         end
         ROP_MODE_RAW12: begin
            o[9:0] = w[9:0];
            o[ROP_F_CMD1] = w[10];
            o[ROP_F_CMD0] = w[11];
         end
         default: o = '0;
      endcase
      return o;
   endfunction

   // does the window hold a sync pattern starting at bit k
   function automatic logic sync_at(input logic [23:0] win, input int k, input logic w10);
      logic [11:0] s;
      s = win[k +: 12] & (w10 ? ROP_MASK10 : ROP_MASK12);
      if (w10) begin
         return (s == ROP_SYNC10_PRI) || (s == ROP_SYNC10_ALT);
      end
      return (s == ROP_SYNC12_PRI) || (s == ROP_SYNC12_ALT);
   endfunction

   rop_mode_t mode;              // current bus mapping
   logic w10;                    // line characters are ten bits
   logic [1:0] pol;              // effective discard policy
   logic [11:0] prev_r;          // previous line word
   logic [3:0] off_r;            // locked bit offset
   logic [3:0] hit_off;          // offset found in this window
   logic hit;                    // sync found in this window
   logic [23:0] win;             // two words, earliest bits low
   logic [11:0] framed_r;        // aligned line word
   logic framed_v_r;             // aligned word waiting
   logic seen_r;                 // sync seen under framing
   logic raw_acc;                // line word taken
   logic src_v;                  // selected source valid
   logic [11:0] src_w;           // selected source word
   logic src_cmd;                // selected source is command
   logic src_viol;               // selected source violation
   logic new_sync;               // arriving char is a sync
   logic new_null;               // arriving char is null fill
   logic acc;                    // arriving char taken
   logic sink_rdy;               // fifo or output reg can take
   logic drop_new;               // arriving char discarded
   logic merge;                  // arriving sync replaces held one
   logic flush;                  // held char leaves without arrival
   logic wr;                     // held char written onward
   logic [13:0] hold_r;          // held mapped char
   logic hold_v_r;               // held char present
   logic hold_sync_r;            // held char is a sync
   logic [13:0] out_r;           // output register
   rop_state_t st_r;             // host read phase
   rop_state_t st_nxt;           // next read phase
   logic pop;                    // host read cycle

   assign mode = mode_of(encoder_bypass_n_i, char_width_select_i);
   assign w10 = char_width_select_i;
   // raw characters cannot be classed, so with the decoder bypassed
   // every character is kept whatever the policy pins say
   assign pol = encoder_bypass_n_i ? policy_i : ROP_POL_KEEP;

   // framing window over the previous and the current line word
   assign win = w10 ? {4'h0, raw_bits_i[9:0], prev_r[9:0]} : {raw_bits_i, prev_r};

   // lowest offset holding a sync pattern
   always_comb begin
      hit = 1'b0;
      hit_off = ROP_OFF_RESET;
      for (int k = 11; k >= 0; k--) begin
         if ((!w10 || k < 10) && sync_at(win, k, w10)) begin
            hit = 1'b1;
            hit_off = 4'(k);
         end
      end
   end

   assign raw_ready_o = !framed_v_r || (!encoder_bypass_n_i ? acc : 1'b1);
   assign raw_acc = raw_valid_i && raw_ready_o;

   // offset lock: framing off falls back to offset zero, unaligned
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         off_r <= ROP_OFF_RESET;
         seen_r <= 1'b0;
      end else if (!framing_enable_i) begin
         off_r <= ROP_OFF_RESET;
         seen_r <= 1'b0;
      end else if (raw_acc && hit) begin
         off_r <= hit_off;
         seen_r <= 1'b1;
      end
   end

   // aligned word stage, bit zero stays the earliest line bit
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev_r <= '0;
         framed_r <= '0;
         framed_v_r <= 1'b0;
      end else if (raw_acc) begin
         prev_r <= raw_bits_i;
         framed_r <= win[(framing_enable_i && hit ? hit_off : off_r) +: 12]
                     & (w10 ? ROP_MASK10 : ROP_MASK12);
         framed_v_r <= 1'b1;
      end else if (!encoder_bypass_n_i ? acc : 1'b1) begin
         framed_v_r <= 1'b0;
      end
   end

   assign framed_word_o = framed_r;
   assign sync_seen_o = seen_r;

   // source select: aligned raw words or decoded characters
   assign src_v = encoder_bypass_n_i ? dec_valid_i : framed_v_r;
   assign src_w = encoder_bypass_n_i ? {2'b00, dec_bits_i} : framed_r;
   assign src_cmd = encoder_bypass_n_i && dec_cmd_i;
   assign src_viol = encoder_bypass_n_i && dec_viol_i;
   assign new_sync = src_cmd && (src_w[9:0] == ROP_CMD_SYNC_PRI || src_w[9:0] == ROP_CMD_SYNC_ALT);
   assign new_null = src_cmd && (src_w[9:0] == ROP_CMD_NULL);

   // discard decisions, taken ahead of the fifo
   assign sink_rdy = fifo_bypass_select_i ? 1'b1 : ff.wr_ready;
   assign acc = src_v && (!hold_v_r || sink_rdy);
   assign dec_ready_o = encoder_bypass_n_i && (!hold_v_r || sink_rdy);
   assign drop_new = pol[1] && new_null;
   assign merge = (pol == ROP_POL_SYNC) && hold_v_r && hold_sync_r && new_sync;
   // under policy one a held sync waits for the next arrival, since only then is it
   // known whether it ends its run; anything else drains at once
   assign flush = !acc && hold_v_r && sink_rdy && !((pol == ROP_POL_SYNC) && hold_sync_r);
   assign wr = (acc && hold_v_r && !drop_new && !merge) || flush;

   // one character hold stage
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hold_r <= '0;
         hold_v_r <= 1'b0;
         hold_sync_r <= 1'b0;
      end else if (acc && !drop_new) begin
         hold_r <= map_char(mode, src_w, src_cmd, src_viol);
         hold_v_r <= 1'b1;
         hold_sync_r <= new_sync;
      end else if (flush) begin
         hold_v_r <= 1'b0;
      end
   end

   // onward write: into the fifo, or straight to the output register
   assign ff.wr_valid = wr && !fifo_bypass_select_i;
   assign ff.wr_data = hold_r;

   // host read phases
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ROP_ST_IDLE: st_nxt = cs_n_i ? ROP_ST_IDLE : ROP_ST_ADDR;
         ROP_ST_ADDR: begin
            if (cs_n_i) begin
               st_nxt = ROP_ST_IDLE;
            end else if (!receive_read_enable_n_i) begin
               st_nxt = ROP_ST_DRIVE;
            end
         end
         ROP_ST_DRIVE: st_nxt = cs_n_i ? ROP_ST_IDLE : ROP_ST_DRIVE;
         default: st_nxt = ROP_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= ROP_ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // a read cycle needs the select seen one cycle earlier
   assign pop = (st_r != ROP_ST_IDLE) && !cs_n_i && !receive_read_enable_n_i;
   assign ff.rd_ready = pop && !fifo_bypass_select_i;

   // output register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_r <= '0;
      end else if (fifo_bypass_select_i) begin
         if (wr) begin
            out_r <= hold_r;
         end
      end else if (ff.rd_ready && ff.rd_valid) begin
         out_r <= ff.rd_data;
      end
   end

   assign receive_char_bus_o = out_r[9:0];
   assign receive_command_bits_o = {out_r[ROP_F_CMD1], out_r[ROP_F_CMD0]};
   assign data_or_command_flag_o = out_r[ROP_F_SCD];
   assign code_violation_flag_o = out_r[ROP_F_VIOL];
   assign receive_bus_oe_n_o = (st_r != ROP_ST_DRIVE);
   assign fifo_empty_o = !ff.rd_valid;

   // checks
   a_hiz_on_deselect: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cs_n_i |=> receive_bus_oe_n_o)
      else $error("bus driven after deselect");
   a_read_drives_bus: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (st_r == ROP_ST_IDLE) && !cs_n_i ##1 !cs_n_i && !receive_read_enable_n_i
      |=> !receive_bus_oe_n_o)
      else $error("read after select did not drive bus");
   a_keep_all_chars: assert property (@(posedge clk_i) disable iff (!rstn_i)
      acc && hold_v_r && (pol == ROP_POL_KEEP) |-> wr)
      else $error("character lost under keep all");
   a_sync_run_merge: assert property (@(posedge clk_i) disable iff (!rstn_i)
      acc && (pol == ROP_POL_SYNC) && hold_v_r && hold_sync_r && new_sync
      |-> !wr ##1 hold_v_r && hold_sync_r)
      else $error("sync run not collapsed");
   a_null_dropped: assert property (@(posedge clk_i) disable iff (!rstn_i)
      acc && pol[1] && new_null |=> $stable(hold_r))
      else $error("null fill kept");
   a_drop_no_fifo: assert property (@(posedge clk_i) disable iff (!rstn_i)
      acc && drop_new && !hold_v_r |-> !ff.wr_valid)
      else $error("discarded char reached fifo");
   a_bypass_direct: assert property (@(posedge clk_i) disable iff (!rstn_i)
      fifo_bypass_select_i && wr |=> out_r == $past(hold_r))
      else $error("bypass char not on output");
   a_unframed_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !framing_enable_i |=> off_r == ROP_OFF_RESET && !sync_seen_o)
      else $error("offset kept while framing off");
   a_sync_locks: assert property (@(posedge clk_i) disable iff (!rstn_i)
      framing_enable_i && raw_acc && hit |=> sync_seen_o && off_r == $past(hit_off))
      else $error("sync did not lock alignment");
endmodule
`default_nettype wire

// File: verif/rop_host_model.sv
// host model: reads received characters with chip select and read enable
// assumes the port samples both strobes on the rising edge of clk_i
`timescale 1ns/1ns
`default_nettype none
module rop_host_model (
   input wire logic clk_i,          // core clock
   output logic cs_n_o,             // chip select, low active
   output logic read_en_n_o,        // read enable, low active
   input wire logic [9:0] bus_i,    // character bus
   input wire logic [1:0] cmd_i,    // command bits
   input wire logic flag_i,         // data or command flag
   input wire logic viol_i,         // code violation flag
   input wire logic oe_n_i          // low: bus driven
);
   // idle: not addressed
   initial begin
      cs_n_o = 1'b1;
      read_en_n_o = 1'b1;
   end
   // one read, entered just after a rising edge
   task automatic read_word(output logic [13:0] word, output logic oe_n_seen);
      cs_n_o = 1'b0; // address the port
      @(posedge clk_i);
      #1 read_en_n_o = 1'b0; // enable in the cycle after select
      @(posedge clk_i);
      #1 read_en_n_o = 1'b1; // one pop only
      @(posedge clk_i);
      #1 word = {viol_i, flag_i, cmd_i, bus_i}; // raw words taken as delivered
      oe_n_seen = oe_n_i;
      cs_n_o = 1'b1; // release so the bus floats again
      // one deselected edge before any further read
      @(posedge clk_i);
      #1;
   endtask
endmodule
`default_nettype wire

// File: verif/receive_output_port_test.sv
// testbench for the receive output port: mapping, discard, fifo, read
// assumes rop_port and its fifo on one 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
module receive_output_port_test;
   import rop_pkg::*;
   logic clk_i, rstn_i, enc_n, width, fbyp, raw_valid, raw_ready;
   logic dec_valid, dec_cmd, dec_viol, dec_ready, cs_n, ren_n;
   logic flag, viol, oe_n, empty, fren, seen;
   logic [1:0] policy, cmdb;
   logic [11:0] raw_bits, fw;
   logic [9:0] dec_bits, bus;
   int fails, tests_run, cycles;
   rop_port dut (.clk_i(clk_i), .rstn_i(rstn_i), .policy_i(policy),
      .encoder_bypass_n_i(enc_n), .char_width_select_i(width),
      .fifo_bypass_select_i(fbyp), .framing_enable_i(fren), .raw_valid_i(raw_valid),
      .raw_bits_i(raw_bits), .raw_ready_o(raw_ready), .framed_word_o(fw), .sync_seen_o(seen),
      .dec_valid_i(dec_valid), .dec_bits_i(dec_bits), .dec_cmd_i(dec_cmd),
      .dec_viol_i(dec_viol), .dec_ready_o(dec_ready), .cs_n_i(cs_n),
      .receive_read_enable_n_i(ren_n), .receive_char_bus_o(bus),
      .receive_command_bits_o(cmdb), .data_or_command_flag_o(flag),
      .code_violation_flag_o(viol), .receive_bus_oe_n_o(oe_n), .fifo_empty_o(empty));
   rop_host_model host (.clk_i(clk_i), .cs_n_o(cs_n), .read_en_n_o(ren_n), .bus_i(bus),
      .cmd_i(cmdb), .flag_i(flag), .viol_i(viol), .oe_n_i(oe_n));
   // clock, 10 ns period
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         final_report();
      end
   end
   task automatic chk(input string name, input logic [13:0] seen, input logic [13:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic setm(input logic e, input logic w, input logic b, input logic [1:0] p);
      enc_n = e;
      width = w;
      fbyp = b;
      policy = p;
   endtask
   // offer one character, hold it until ready is seen at an edge
   task automatic push(input logic raw, input logic [11:0] v, input logic c, output bit ok);
      int n;
      ok = 0;
      raw_bits = v;
      dec_bits = v[9:0];
      dec_cmd = c;
      if (raw) raw_valid = 1'b1;
      else dec_valid = 1'b1;
      for (n = 0; n < 20 && !ok; n++) begin
         @(negedge clk_i);
         ok = raw ? (raw_ready === 1'b1) : (dec_ready === 1'b1);
         @(posedge clk_i);
      end
      #1 raw_valid = 1'b0;
      dec_valid = 1'b0;
      // valid stays low across one edge before the next offer
      @(posedge clk_i) #1;
   endtask
   // wait for a stored word, then read it through the host
   task automatic rd(output logic [13:0] w);
      logic o;
      int n;
      for (n = 0; n < 20 && empty !== 1'b0; n++) @(posedge clk_i) #1;
      host.read_word(w, o);
      chk("oe_n while read", {13'h0, o}, 14'h0000);
   endtask
   task automatic t_enc8();
      logic [13:0] w;
      bit ok;
      setm(1'b1, 1'b1, 1'b0, ROP_POL_KEEP);
      dec_viol = 1'b1;
      push(1'b0, 12'h0A5, 1'b0, ok);
      dec_viol = 1'b0;
      push(1'b0, 12'h005, 1'b1, ok);
      rd(w);
      chk("enc8 data", w & 14'h30FF, 14'h20A5);
      @(posedge clk_i) #1;
      chk("oe_n after deselect", {13'h0, oe_n}, 14'h0001);
      rd(w);
      chk("enc8 command", w, 14'h1600);
   endtask
   task automatic t_enc10_raw();
      logic [13:0] w;
      bit ok;
      setm(1'b1, 1'b0, 1'b0, ROP_POL_KEEP);
      push(1'b0, 12'h2B4, 1'b0, ok);
      rd(w);
      chk("enc10 data", w & 14'h23FF, 14'h0354);
      setm(1'b0, 1'b1, 1'b0, ROP_POL_KEEP);
      // each line word leaves the framing stage when the next is taken
      push(1'b1, 12'h2C6, 1'b0, ok);
      push(1'b1, 12'hA5C, 1'b0, ok);
      rd(w);
      chk("raw10 leftover", w, 14'h0000);
      rd(w);
      chk("raw10", w & 14'h03FF, 14'h02C6);
      setm(1'b0, 1'b0, 1'b0, ROP_POL_KEEP);
      push(1'b1, 12'h000, 1'b0, ok);
      rd(w);
      chk("raw12", w & 14'h0FFF, 14'h065C);
   endtask
   task automatic t_discard();
      logic [13:0] w;
      bit ok;
      int p;
      setm(1'b1, 1'b1, 1'b0, ROP_POL_SYNC);
      push(1'b0, {2'h0, ROP_CMD_SYNC_PRI}, 1'b1, ok);
      push(1'b0, {2'h0, ROP_CMD_SYNC_ALT}, 1'b1, ok);
      push(1'b0, {2'h0, ROP_CMD_SYNC_PRI}, 1'b1, ok);
      push(1'b0, 12'h033, 1'b0, ok);
      rd(w);
      chk("kept sync flag", w & 14'h1000, 14'h1000);
      rd(w);
      chk("after sync run", w & 14'h10FF, 14'h0033);
      chk("empty after run", {13'h0, empty}, 14'h0001);
      for (p = 2; p < 4; p++) begin
         setm(1'b1, 1'b1, 1'b0, 2'(p));
         push(1'b0, {2'h0, ROP_CMD_NULL}, 1'b1, ok);
         push(1'b0, 12'h044, 1'b0, ok);
         rd(w);
         chk("after null", w & 14'h10FF, 14'h0044);
         chk("empty after null", {13'h0, empty}, 14'h0001);
      end
   endtask
   task automatic t_fill();
      logic [13:0] w;
      bit ok;
      int i;
      setm(1'b1, 1'b1, 1'b0, ROP_POL_KEEP);
      ok = 1;
      for (i = 0; i < 40 && ok; i++) push(1'b0, 12'(i + 8'h40), 1'b0, ok);
      chk("accepted count", 14'(i - 1), 14'(ROP_FIFO_DEPTH + 1));
      for (i = 0; i < ROP_FIFO_DEPTH + 1; i++) begin
         rd(w);
         chk("drain order", w & 14'h00FF, 14'(i + 8'h40));
      end
      chk("empty after drain", {13'h0, empty}, 14'h0001);
   endtask
   task automatic t_bypass();
      bit ok;
      setm(1'b0, 1'b1, 1'b1, ROP_POL_KEEP);
      // a word shows on the bus once the following word is taken
      push(1'b1, 12'h155, 1'b0, ok);
      push(1'b1, 12'h2AA, 1'b0, ok);
      repeat (4) @(posedge clk_i) #1;
      chk("bypass first", {4'h0, bus}, 14'h0155);
      push(1'b1, 12'h000, 1'b0, ok);
      repeat (4) @(posedge clk_i) #1;
      chk("bypass second", {4'h0, bus}, 14'h02AA);
   endtask
   // primary sync split at bit offset three across two line words
   task automatic t_framing();
      bit ok;
      setm(1'b0, 1'b1, 1'b1, ROP_POL_KEEP);
      fren = 1'b1;
      push(1'b1, 12'h3C0, 1'b0, ok);
      chk("no early lock", {13'h0, seen}, 14'h0000);
      push(1'b1, 12'h001, 1'b0, ok);
      chk("framed sync", {2'h0, fw}, 14'(ROP_SYNC10_PRI));
      chk("sync seen", {13'h0, seen}, 14'h0001);
      repeat (4) @(posedge clk_i) #1;
      chk("aligned on bus", {4'h0, bus}, 14'(ROP_SYNC10_PRI));
      fren = 1'b0;
      @(posedge clk_i) #1;
      chk("lock dropped", {13'h0, seen}, 14'h0000);
   endtask
   // main sequence
   initial begin
      fails = 0;
      tests_run = 0;
      cycles = 0;
      rstn_i = 1'b0;
      setm(1'b1, 1'b1, 1'b0, ROP_POL_KEEP);
      raw_valid = 1'b0;
      raw_bits = 12'h000;
      dec_valid = 1'b0;
      dec_bits = 10'h000;
      dec_cmd = 1'b0;
      dec_viol = 1'b0;
      fren = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 rstn_i = 1'b1;
      chk("oe_n at reset", {12'h0, oe_n, empty}, 14'h0003);
      t_enc8();
      t_enc10_raw();
      t_discard();
      t_fill();
      t_bypass();
      t_framing();
      final_report();
   end
endmodule
`default_nettype wire
